// [logic/pei_error_inserter.sv]
// Purpose: T1 transmit payload error inserter with Avalon-MM registers
// Assumes: Stream inputs and t1Mode come from logic on mclk
// Notes: Output stream is the input delayed by one clock cycle
`timescale 1ns/1ps
module pei_error_inserter
    import pei_pkg::*;
(
    input wire logic mclk,
    input wire logic rst,
    input wire logic [ADDR_W-1:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [3:0] byteenable,
    input wire logic [DATA_W-1:0] writedata,
    output logic [DATA_W-1:0] readdata,
    output logic waitrequest,
    input wire logic t1Mode,
    input wire pei_chan_t chanIn,
    input wire pei_bit_t txIn,
    output pei_bit_t txOut,
    output logic errPulse
);

    // --------------------------------------------------------------
    // Register file
    // --------------------------------------------------------------
    logic [7:0] ctrl_r;
    logic [QUOTA_W-1:0] quota_r;
    logic [QUOTA_W-1:0] left_r;
    logic [QUOTA_W-1:0] left_nxt;
    logic [DATA_W-1:0] readdata_r;
    logic rdDone_r;
    logic [7:0] regIdx;
    logic wrLane0;

    assign regIdx = address[ADDR_W-1:2];
    assign wrLane0 = write && byteenable[0];

    // Reads take one wait state; writes complete at once
    assign waitrequest = read && !rdDone_r;
    assign readdata = readdata_r;

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            ctrl_r <= CTRL_RST;
        end else if (wrLane0 && regIdx == IDX_CTRL) begin
            ctrl_r <= writedata[7:0];
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            quota_r <= QUOTA_RST;
        end else if (wrLane0 && regIdx == IDX_QUOTA_LO) begin
            quota_r[7:0] <= writedata[7:0];
        end else if (wrLane0 && regIdx == IDX_QUOTA_HI) begin
            quota_r[QUOTA_W-1:8] <= writedata[QUOTA_HI_MSB:0];
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            rdDone_r <= 1'b0;
        end else begin
            rdDone_r <= read && !rdDone_r;
        end
    end

    // Left count is sampled live so software sees it at any moment
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            readdata_r <= '0;
        end else if (read && !rdDone_r) begin
            case (regIdx)
                IDX_CTRL: readdata_r <= {24'h000000, ctrl_r};
                IDX_QUOTA_LO: readdata_r <= {24'h000000, quota_r[7:0]};
                IDX_QUOTA_HI: readdata_r <= {30'h0, quota_r[QUOTA_W-1:8]};
                IDX_LEFT_LO: readdata_r <= {24'h000000, left_r[7:0]};
                IDX_LEFT_HI: readdata_r <= {30'h0, left_r[QUOTA_W-1:8]};
                default: readdata_r <= '0;
            endcase
        end
    end

    // --------------------------------------------------------------
    // Quota load on rising edge of the load bit
    // --------------------------------------------------------------
    logic loadPrev_r;
    logic loadRise;
    logic constMode;

    assign constMode = ctrl_r[CTRL_CONST_BIT];
    // A bit left high never reloads; host must clear and set again
    assign loadRise = ctrl_r[CTRL_LOAD_BIT] && !loadPrev_r;

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            loadPrev_r <= 1'b0;
        end else begin
            loadPrev_r <= ctrl_r[CTRL_LOAD_BIT];
        end
    end

    // --------------------------------------------------------------
    // Rate and bit counting
    // --------------------------------------------------------------
    logic [RATE_W-1:0] rateAct_r;
    logic [CNT_W-1:0] cnt_r;
    logic eligible;
    logic lastBit;
    logic injNxt;
    logic rateSwap;

    // A new rate code restarts the group so the first error lands a full group in
    assign rateSwap = txIn.valid && txIn.frameStart && ctrl_r[RATE_W-1:0] != rateAct_r;

    // Rate changes only between frames so a frame never mixes rates
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            rateAct_r <= RATE_OFF;
        end else if (txIn.valid && txIn.frameStart) begin
            rateAct_r <= ctrl_r[RATE_W-1:0];
        end
    end

    assign eligible = txIn.valid && t1Mode && !txIn.frameBit
        && (!chanIn.selMode || chanIn.chanHit)
        && rateAct_r != RATE_OFF;
    assign lastBit = cnt_r == peiTerm(rateAct_r);
    assign injNxt = eligible && lastBit
        && (constMode || left_r != QUOTA_RST);

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            cnt_r <= CNT_RST;
        end else if (rateSwap) begin
            cnt_r <= CNT_RST;
        end else if (eligible) begin
            cnt_r <= lastBit ? CNT_RST : cnt_r + CNT_ONE;
        end
    end

    // Load wins over a decrement in the same cycle
    always_comb begin
        left_nxt = left_r;
        if (loadRise) begin
            left_nxt = quota_r;
        end else if (injNxt && !constMode) begin
            left_nxt = left_r - LEFT_ONE;
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            left_r <= QUOTA_RST;
        end else begin
            left_r <= left_nxt;
        end
    end

    // --------------------------------------------------------------
    // Output stream
    // --------------------------------------------------------------
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            txOut <= '0;
            errPulse <= 1'b0;
        end else begin
            txOut.valid <= txIn.valid;
            txOut.data <= txIn.data ^ injNxt;
            txOut.frameBit <= txIn.frameBit;
            txOut.frameStart <= txIn.frameStart;
            errPulse <= injNxt;
        end
    end

    // --------------------------------------------------------------
    // Assertions
    // --------------------------------------------------------------
    default clocking cbMain @(posedge mclk);
    endclocking
    default disable iff (rst);

    sequence sLoadRise;
        !ctrl_r[CTRL_LOAD_BIT] ##1 ctrl_r[CTRL_LOAD_BIT] && !$past(ctrl_r[CTRL_LOAD_BIT], 2);
    endsequence

    sequence sLoadHeld;
        ctrl_r[CTRL_LOAD_BIT] [*2];
    endsequence

    a_fbit_untouched: assert property (
        txIn.valid && txIn.frameBit |=> txOut.data == $past(txIn.data) && !errPulse)
        else $error("Framing bit was inverted");

    a_zero_rate_quiet: assert property (
        rateAct_r == RATE_OFF |=> !errPulse)
        else $error("Error inserted with rate zero");

    a_load_next_cycle: assert property (
        sLoadRise |=> left_r == $past(quota_r))
        else $error("Quota not loaded one cycle after load rise");

    a_held_no_reload: assert property (
        sLoadHeld |=> left_r <= $past(left_r))
        else $error("Held load bit reloaded the quota");

    a_count_down: assert property (
        injNxt && !constMode && !loadRise |=> left_r == $past(left_r) - LEFT_ONE && errPulse)
        else $error("Remaining count not decremented on inversion");

    a_stop_at_zero: assert property (
        !constMode && left_r == QUOTA_RST && !loadRise |-> !injNxt ##1 left_r == QUOTA_RST)
        else $error("Error inserted with no quota left");

    a_rate_at_frame: assert property (
        !$past(txIn.valid && txIn.frameStart) |-> rateAct_r == $past(rateAct_r))
        else $error("Rate changed inside a frame");

    a_group_length: assert property (
        injNxt |-> cnt_r == peiTerm(rateAct_r) ##1 cnt_r == CNT_RST || $past(txIn.frameStart))
        else $error("Error not on last bit of group");

    a_t1_only: assert property (
        !t1Mode |-> !injNxt)
        else $error("Error inserted outside T1 mode");

    a_chan_gate: assert property (
        chanIn.selMode && !chanIn.chanHit |-> !injNxt)
        else $error("Unselected channel corrupted");

    a_const_runs: assert property (
        constMode && eligible && lastBit |=> errPulse && left_r == $past(left_r)
            || $past(loadRise))
        else $error("Constant mode missed an error");

    // --------------------------------------------------------------
    // Bus and stream checks
    // --------------------------------------------------------------
    sequence sReadReq;
        read && !rdDone_r;
    endsequence

    sequence sReadDone;
        rdDone_r && !waitrequest;
    endsequence

    a_write_no_wait: assert property (
        write |-> !waitrequest)
        else $error("Write was stalled");

    a_read_one_wait: assert property (
        sReadReq |-> waitrequest ##1 sReadDone)
        else $error("Read did not finish after one wait state");

    a_left_lo_read: assert property (
        sReadReq && regIdx == IDX_LEFT_LO |=> readdata == {24'h000000, $past(left_r[7:0])})
        else $error("Low left count read back wrong");

    a_left_hi_read: assert property (
        sReadReq && regIdx == IDX_LEFT_HI |=> readdata == {30'h0, $past(left_r[QUOTA_W-1:8])})
        else $error("High left count read back wrong");

    a_ctrl_store: assert property (
        wrLane0 && regIdx == IDX_CTRL |=> ctrl_r == $past(writedata[7:0]))
        else $error("Control write not stored");

    a_quota_lo_store: assert property (
        wrLane0 && regIdx == IDX_QUOTA_LO |=> quota_r[7:0] == $past(writedata[7:0]))
        else $error("Low quota write not stored");

    a_quota_hi_store: assert property (
        wrLane0 && regIdx == IDX_QUOTA_HI |=>
            quota_r[QUOTA_W-1:8] == $past(writedata[QUOTA_HI_MSB:0]))
        else $error("High quota write not stored");

    a_left_read_only: assert property (
        wrLane0 && (regIdx == IDX_LEFT_LO || regIdx == IDX_LEFT_HI) && !loadRise && !injNxt
            |=> left_r == $past(left_r))
        else $error("Left count changed by a write");

    a_out_follow: assert property (
        1'b1 |=> txOut.valid == $past(txIn.valid) && txOut.frameBit == $past(txIn.frameBit)
            && txOut.frameStart == $past(txIn.frameStart))
        else $error("Output slot markers not delayed by one cycle");

    a_clean_pass: assert property (
        !injNxt |=> txOut.data == $past(txIn.data) && !errPulse)
        else $error("Bit changed without an insertion");

    a_flip_marked: assert property (
        injNxt |=> txOut.data != $past(txIn.data) && errPulse)
        else $error("Insertion did not invert the bit");

    a_t1_quiet: assert property (
        !t1Mode |=> !errPulse)
        else $error("Error pulse outside T1 mode");

    a_count_step: assert property (
        eligible && !lastBit && !rateSwap |=> cnt_r == $past(cnt_r) + CNT_ONE)
        else $error("Eligible bit not counted");

    a_count_hold: assert property (
        !eligible && !rateSwap |=> cnt_r == $past(cnt_r))
        else $error("Ineligible bit was counted");

    a_count_bound: assert property (
        cnt_r <= peiTerm(rateAct_r))
        else $error("Group counter past its last bit");

    a_rate_swap: assert property (
        rateSwap |=> cnt_r == CNT_RST && rateAct_r == $past(ctrl_r[RATE_W-1:0]))
        else $error("Rate change at frame start not applied");

    a_const_left_kept: assert property (
        constMode && !loadRise |=> left_r == $past(left_r))
        else $error("Constant mode changed the left count");

    a_load_copy: assert property (
        loadRise |=> left_r == $past(quota_r))
        else $error("Load rise did not copy the quota");

    a_counted_gate: assert property (
        !constMode && left_r == QUOTA_RST |-> !injNxt)
        else $error("Counted mode inserted past its quota");

    a_load_held_quiet: assert property (
        ctrl_r[CTRL_LOAD_BIT] && loadPrev_r |-> !loadRise)
        else $error("Held load bit seen as a rise");

    a_pulse_single: assert property (
        errPulse |=> !errPulse)
        else $error("Two errors in consecutive slots");

endmodule

// [logic/pei_pkg.sv]
// Purpose: Shared constants and types for the T1 payload error inserter
// Assumes: One 125 MHz clock; bus and stream both on that clock
// Notes: Register byte address is four times the register index
// What this block does
// - Corrupt only T1 payload bits on transmit
// - Corrupt every channel or only selected ones
// - Invert the last bit of each counted group
// - Framing bits never counted, never inverted
// - New rate takes effect at frame boundary
// - Code n gives one error per 2^(n+3)
// - Rate zero means no errors at all
// - Constant mode ignores quota, errors run continuously
// - Counted mode inserts only the loaded quota
// - Load rise copies quota next clock cycle
// - Load acts on rising edge, held ignored
// - Ten-bit quota split over two registers
// - Quota zero inserts none, n inserts n
// - Read-only ten-bit count of errors left
package pei_pkg;
    localparam int ADDR_W = 10;
    localparam int DATA_W = 32;
    localparam int RATE_W = 4;
    localparam int CNT_W = 18;
    localparam int QUOTA_W = 10;

    // Register indices, byte address = index * 4
    localparam logic [7:0] IDX_CTRL = 8'heb;
    localparam logic [7:0] IDX_QUOTA_LO = 8'hec;
    localparam logic [7:0] IDX_QUOTA_HI = 8'hed;
    localparam logic [7:0] IDX_LEFT_LO = 8'hee;
    localparam logic [7:0] IDX_LEFT_HI = 8'hef;

    // Field positions in insertion_rate_ctrl and the quota high register
    localparam int CTRL_CONST_BIT = 4;
    localparam int CTRL_LOAD_BIT = 7;
    localparam int QUOTA_HI_MSB = 1;

    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [QUOTA_W-1:0] QUOTA_RST = 10'h000;
    localparam logic [RATE_W-1:0] RATE_OFF = 4'h0;
    localparam logic [CNT_W-1:0] CNT_RST = 18'h00000;
    localparam logic [CNT_W-1:0] CNT_ONE = 18'h00001;
    localparam logic [QUOTA_W-1:0] LEFT_ONE = 10'h001;
    localparam int RATE_LOG_OFS = 3;

    // One bit slot of the transmit payload stream
    typedef struct packed {
        logic valid;
        logic data;
        logic frameBit;
        logic frameStart;
    } pei_bit_t;

    // Channel gating supplied by the channel-select logic
    typedef struct packed {
        logic selMode;
        logic chanHit;
    } pei_chan_t;

    // Last count value of a group: 2^(rate+3) - 1
    function automatic logic [CNT_W-1:0] peiTerm(input logic [RATE_W-1:0] rate);
        logic [CNT_W:0] one;
        one = {{CNT_W{1'b0}}, 1'b1};
        peiTerm = CNT_W'((one << (int'(rate) + RATE_LOG_OFS)) - 1'b1);
    endfunction
endpackage

// [tb/pei_frame_src.sv]
// Purpose: Transmit framer datapath source feeding the inserter
// Assumes: One bit slot per mclk, F-bit slot opens each frame
// Notes: Data is a short LFSR so an inversion is always visible
`timescale 1ns/1ps
module pei_frame_src
    import pei_pkg::*;
#(
    parameter int FLEN = 193
)(
    input wire logic mclk,
    input wire logic rst,
    output pei_bit_t txIn
);
    logic [8:0] slot_r;
    logic [3:0] pat_r;
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            slot_r <= 9'h000;
            pat_r <= 4'h1;
        end else begin
            slot_r <= (slot_r == 9'(FLEN - 1)) ? 9'h000 : slot_r + 9'h001;
            pat_r <= {pat_r[2:0], pat_r[3] ^ pat_r[2]};
        end
    end
    // F-bit always leads the frame
    assign txIn = '{valid: !rst, data: pat_r[3], frameBit: slot_r == 9'h000,
                    frameStart: slot_r == 9'h000};
endmodule

// [tb/tb.sv]
// Purpose: Self-checking bench for the payload error inserter
// Assumes: Stream source sends one slot per clock
// Notes: Errors are counted as data flips between txIn and txOut
`timescale 1ns/1ps
module tb;
    import pei_pkg::*;
    localparam int FLEN = 193;
    logic mclk, rst, read, write, t1Mode, errPulse, waitrequest;
    logic [ADDR_W-1:0] address;
    logic [3:0] byteenable;
    logic [DATA_W-1:0] writedata, readdata;
    logic [7:0] d;
    pei_chan_t chanIn;
    pei_bit_t txIn, txOut, prevIn;
    int fail_count, samples_checked, flips;
    pei_error_inserter DUT (.mclk, .rst, .address, .read, .write, .byteenable,
        .writedata, .readdata, .waitrequest, .t1Mode, .chanIn, .txIn, .txOut, .errPulse);
    pei_frame_src #(.FLEN(FLEN)) SRC (.mclk, .rst, .txIn);
    initial begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            fail_count++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic close_out();
        $display("checks=%0d mismatches=%0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    // Sample waitrequest 1 ns after each edge; the edge after low ends it
    task automatic bus(input logic rd, input logic [7:0] idx, input logic [7:0] wd);
        logic w;
        address <= {idx, 2'b00};
        writedata <= {24'h000000, wd};
        read <= rd;
        write <= !rd;
        do begin
            #1 w = waitrequest;
            @(posedge mclk);
        end while (w !== 1'b0);
        d = readdata[7:0];
        read <= 1'b0;
        write <= 1'b0;
        @(posedge mclk);
    endtask
    task automatic wr(input logic [7:0] idx, input logic [7:0] v);
        bus(1'b0, idx, v);
    endtask
    task automatic rdc(input logic [7:0] idx, input logic [7:0] exp);
        bus(1'b1, idx, 8'h00);
        chk({24'h0, d}, {24'h0, exp});
    endtask
    task automatic win(input int n, input int exp);
        int f0;
        f0 = flips;
        repeat (n) @(posedge mclk);
        chk(32'(flips - f0), 32'(exp));
    endtask
    always @(posedge mclk) begin
        if (!rst && txOut.valid) begin
            if (txOut.data !== prevIn.data) flips <= flips + 1;
            chk({31'h0, errPulse}, {31'h0, txOut.data !== prevIn.data});
            if (txOut.frameBit) chk({31'h0, txOut.data}, {31'h0, prevIn.data});
        end
        prevIn <= txIn;
    end
    // ----------------------------------------
    // Tests
    // ----------------------------------------
    initial begin
        rst = 1'b1; read = 1'b0; write = 1'b0; address = '0; byteenable = 4'h1;
        writedata = '0; t1Mode = 1'b1; chanIn = '{selMode: 1'b0, chanHit: 1'b0};
        repeat (3) @(posedge mclk);
        rst <= 1'b0;
        @(posedge mclk);
        rdc(IDX_CTRL, 8'h00);
        wr(IDX_LEFT_LO, 8'h5a);
        rdc(IDX_LEFT_LO, 8'h00);
        rdc(8'h10, 8'h00);
        $display("test registers done");
        for (int r = 0; r < 4; r++) begin
            wr(IDX_CTRL, 8'h10 | 8'(r));
            repeat (2 * FLEN) @(posedge mclk);
            win(2 * FLEN, r == 0 ? 0 : 48 >> r);
        end
        for (int h = 0; h < 2; h++) begin
            chanIn <= '{selMode: 1'b1, chanHit: 1'(h)};
            win(2 * FLEN, h * 6);
        end
        $display("test constant rates done");
        chanIn <= '{selMode: 1'b0, chanHit: 1'b0};
        wr(IDX_CTRL, 8'h1f);
        repeat (2 * FLEN) @(posedge mclk);
        win(2 * FLEN, 0);
        t1Mode <= 1'b0;
        wr(IDX_CTRL, 8'h01);
        wr(IDX_QUOTA_LO, 8'h00);
        wr(IDX_QUOTA_HI, 8'h01);
        wr(IDX_CTRL, 8'h81);
        rdc(IDX_QUOTA_LO, 8'h00);
        rdc(IDX_QUOTA_HI, 8'h01);
        rdc(IDX_LEFT_LO, 8'h00);
        rdc(IDX_LEFT_HI, 8'h01);
        win(2 * FLEN, 0);
        t1Mode <= 1'b1;
        win(4600, 256);
        rdc(IDX_LEFT_LO, 8'h00);
        rdc(IDX_LEFT_HI, 8'h00);
        wr(IDX_QUOTA_LO, 8'h02);
        wr(IDX_QUOTA_HI, 8'h00);
        wr(IDX_CTRL, 8'h81);
        win(400, 0);
        wr(IDX_CTRL, 8'h01);
        wr(IDX_CTRL, 8'h81);
        win(400, 2);
        $display("test counted mode done");
        close_out();
    end
    initial begin
        repeat (20000) @(posedge mclk);
        fail_count++;
        close_out();
    end
endmodule
